// ### rtl/pcmg_clock_ctrl.sv
// Primary clock network control: source sampling, two dynamic muxes,
// eight network gates and the edge bridge select muxes.
// Assumes clock sources arrive from outside the system clock domain and
// that select and enable inputs come from core logic on the system clock.
//
// How it works
// R1: There are eight separate primary clock networks, each with its own output.
// R2: Only the first two networks carry a dynamic two-input clock mux; the rest take one source.
// R3: A dynamic mux passes input zero when its select is low and input one when it is high.
// R4: Input zero is the default source, chosen from reset until core logic raises the select.
// R5: The mux follows a new select on the next system clock edge with no synchronisation, so its output may glitch.
// R6: Each mux output drives its primary network, and both inputs may be any primary source.
// R7: Primary sources are clock pins, PLL outputs, divider outputs and internal nodes.
// R8: Each network has a gate whose enable low stops the clock and high passes it.
// R9: Core logic should drop a network's enable whenever that domain is idle to save power.
// R10: Each edge clock has a bridge select mux choosing between two clock sources.
// R11: A disabled gate holds its output at a constant low level.
module pcmg_clock_ctrl
  import pcmg_pkg::*;
#(
  parameter int NUM_NETS  = pcmg_pkg::NUM_PRIMARY_NETS,
  parameter int NUM_MUX   = pcmg_pkg::NUM_MUX_NETS,
  parameter int NUM_EDGE  = pcmg_pkg::NUM_EDGE_CLOCKS,
  parameter int NUM_PIN   = pcmg_pkg::NUM_PIN_SOURCES,
  parameter int NUM_PLL   = pcmg_pkg::NUM_PLL_SOURCES,
  parameter int NUM_DIV   = pcmg_pkg::NUM_DIV_SOURCES,
  parameter int NUM_NODE  = pcmg_pkg::NUM_NODE_SOURCES,
  parameter int NUM_SRC   = NUM_PIN + NUM_PLL + NUM_DIV + NUM_NODE,
  parameter int SRCW      = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1
) (
  // Clock and reset
  input  wire logic                           CLK_SYS,
  input  wire logic                           RESET,
  // Primary clock sources
  input  wire logic [NUM_PIN-1:0]             PIN_CLK,
  input  wire logic [NUM_PLL-1:0]             PLL_CLK,
  input  wire logic [NUM_DIV-1:0]             DIVIDED_CLOCK_OUTPUT,
  input  wire logic [NUM_NODE-1:0]            NODE_CLK,
  // Source routing from core logic
  input  wire logic [NUM_NETS-1:0][SRCW-1:0]  NET_SRC,
  input  wire logic [NUM_MUX-1:0][SRCW-1:0]   MUX_ONE_SRC,
  // Dynamic mux selects and gate enables from core logic
  input  wire logic [NUM_MUX-1:0]             MUX_SEL,
  input  wire logic [NUM_NETS-1:0]            GATE_ENABLE,
  // Edge bridge
  input  wire logic [NUM_EDGE-1:0]            EDGE_CLOCK_IN_ZERO,
  input  wire logic [NUM_EDGE-1:0]            EDGE_CLOCK_IN_ONE,
  input  wire logic [NUM_EDGE-1:0]            EDGE_BRIDGE_SOURCE_SELECT,
  // Outputs
  output logic [NUM_MUX-1:0]                  MUXED_CLOCK_OUT,
  output logic [NUM_NETS-1:0]                 PRIMARY_CLOCK_OUT,
  output logic [NUM_EDGE-1:0]                 EDGE_CLOCK_OUT
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NUM_NETS != NUM_PRIMARY_NETS) begin : g_bad_nets
    $error("Network count must be eight."); // R1
  end
  if (NUM_MUX != NUM_MUX_NETS) begin : g_bad_mux
    $error("Exactly two networks carry a dynamic mux."); // R2
  end
  if (NUM_PIN < 1 || NUM_PLL < 1 || NUM_DIV < 1 || NUM_NODE < 1) begin : g_bad_src
    $error("Every source kind needs at least one input."); // R7
  end
  if (NUM_SRC != NUM_PIN + NUM_PLL + NUM_DIV + NUM_NODE || (1 << SRCW) < NUM_SRC) begin : g_bad_idx
    $error("Source count or index width does not match the source inputs."); // R7
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  function automatic logic pick_source(input logic [NUM_SRC-1:0] srcs, input logic [SRCW-1:0] idx);
    pick_source = (32'(idx) < NUM_SRC) ? srcs[idx] : CLOCK_RESET_LEVEL;
  endfunction : pick_source

  // ----------------------------------------------------------------
  // Source sampling
  // ----------------------------------------------------------------
  // Every source is foreign to the system clock, so each passes two flops.
  logic [NUM_SRC-1:0]  src_s1_q;
  logic [NUM_SRC-1:0]  src_s2_q;
  logic [NUM_SRC-1:0]  src_raw;
  logic [NUM_EDGE-1:0] edge0_s1_q;
  logic [NUM_EDGE-1:0] edge0_s2_q;
  logic [NUM_EDGE-1:0] edge1_s1_q;
  logic [NUM_EDGE-1:0] edge1_s2_q;

  assign src_raw = {NODE_CLK, DIVIDED_CLOCK_OUTPUT, PLL_CLK, PIN_CLK}; // R7

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      src_s1_q <= '0;
      src_s2_q <= '0;
    end else begin
      src_s1_q <= src_raw;
      src_s2_q <= src_s1_q;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      edge0_s1_q <= '0;
      edge0_s2_q <= '0;
      edge1_s1_q <= '0;
      edge1_s2_q <= '0;
    end else begin
      edge0_s1_q <= EDGE_CLOCK_IN_ZERO;
      edge0_s2_q <= edge0_s1_q;
      edge1_s1_q <= EDGE_CLOCK_IN_ONE;
      edge1_s2_q <= edge1_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Dynamic muxes
  // ----------------------------------------------------------------
  // The select is taken straight from core logic with no handshake between
  // the two clocks; switching mid-pulse can leave a runt on the output.
  logic [NUM_MUX-1:0] mux_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      mux_q <= '0;
    end else begin
      for (int m = 0; m < NUM_MUX; m++) begin
        if (MUX_SEL[m] == SEL_INPUT_ZERO) begin
          mux_q[m] <= pick_source(src_s2_q, NET_SRC[m]); // R3 R4 R5 R6
        end else begin
          mux_q[m] <= pick_source(src_s2_q, MUX_ONE_SRC[m]); // R3 R5 R6
        end
      end
    end
  end

  assign MUXED_CLOCK_OUT = mux_q;

  // ----------------------------------------------------------------
  // Primary networks and gates
  // ----------------------------------------------------------------
  for (genvar n = 0; n < NUM_NETS; n++) begin : g_net
    pcmg_net_if net_if ();

    if (n < NUM_MUX) begin : g_muxed
      assign net_if.gate_clock_in = mux_q[n]; // R2 R6
    end else begin : g_plain
      assign net_if.gate_clock_in = pick_source(src_s2_q, NET_SRC[n]); // R2
    end
    assign net_if.gate_enable = GATE_ENABLE[n]; // R8 R9

    pcmg_gate u_gate (
      .clk_sys (CLK_SYS),
      .reset   (RESET),
      .net     (net_if.gate)
    );

    assign PRIMARY_CLOCK_OUT[n] = net_if.gated_clock_out; // R1
  end

  // ----------------------------------------------------------------
  // Edge bridge select muxes
  // ----------------------------------------------------------------
  logic [NUM_EDGE-1:0] edge_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      edge_q <= '0;
    end else begin
      for (int e = 0; e < NUM_EDGE; e++) begin
        edge_q[e] <= (EDGE_BRIDGE_SOURCE_SELECT[e] == SEL_INPUT_ZERO) ? edge0_s2_q[e] : edge1_s2_q[e]; // R10
      end
    end
  end

  assign EDGE_CLOCK_OUT = edge_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mux_zero;
    @(posedge CLK_SYS) disable iff (RESET)
      !MUX_SEL[0] |=> MUXED_CLOCK_OUT[0] == pick_source($past(src_s2_q), $past(NET_SRC[0]));
  endproperty
  a_mux_zero: assert property (p_mux_zero) else $error("Mux zero did not pass input zero."); // R3

  property p_mux_one;
    @(posedge CLK_SYS) disable iff (RESET)
      MUX_SEL[1] |=> MUXED_CLOCK_OUT[1] == pick_source($past(src_s2_q), $past(MUX_ONE_SRC[1]));
  endproperty
  a_mux_one: assert property (p_mux_one) else $error("Mux one did not pass input one."); // R3

  sequence s_sel_switch;
    $changed(MUX_SEL[0]);
  endsequence

  property p_no_sync;
    @(posedge CLK_SYS) disable iff (RESET)
      s_sel_switch |=> MUXED_CLOCK_OUT[0] ==
        ($past(MUX_SEL[0]) ? pick_source($past(src_s2_q), $past(MUX_ONE_SRC[0]))
                           : pick_source($past(src_s2_q), $past(NET_SRC[0])));
  endproperty
  a_no_sync: assert property (p_no_sync) else $error("Mux waited after a select change."); // R5

  property p_default_zero;
    @(posedge CLK_SYS)
      RESET ##1 (!RESET && !MUX_SEL[0]) |=> MUXED_CLOCK_OUT[0] == pick_source($past(src_s2_q), $past(NET_SRC[0]));
  endproperty
  a_default_zero: assert property (p_default_zero) else $error("Input zero not the default."); // R4

  property p_mux_drives_net;
    @(posedge CLK_SYS) disable iff (RESET)
      GATE_ENABLE[1] |=> PRIMARY_CLOCK_OUT[1] == $past(MUXED_CLOCK_OUT[1]);
  endproperty
  a_mux_drives_net: assert property (p_mux_drives_net) else $error("Mux output not on its network."); // R6

  property p_plain_net;
    @(posedge CLK_SYS) disable iff (RESET)
      GATE_ENABLE[2] |=> PRIMARY_CLOCK_OUT[2] == pick_source($past(src_s2_q), $past(NET_SRC[2]));
  endproperty
  a_plain_net: assert property (p_plain_net) else $error("Plain network took a wrong source."); // R2

  property p_source_path;
    @(posedge CLK_SYS) disable iff (RESET)
      (!$past(RESET, 2) && !$past(RESET)) |-> src_s2_q[0] == $past(PIN_CLK[0], 2);
  endproperty
  a_source_path: assert property (p_source_path) else $error("Pin source not sampled in two stages."); // R7

  property p_edge_select;
    @(posedge CLK_SYS) disable iff (RESET)
      EDGE_BRIDGE_SOURCE_SELECT[0] |=> EDGE_CLOCK_OUT[0] == $past(edge1_s2_q[0]);
  endproperty
  a_edge_select: assert property (p_edge_select) else $error("Edge bridge did not pass input one."); // R10

  property p_gate_stop;
    @(posedge CLK_SYS) disable iff (RESET)
      !GATE_ENABLE[7] |=> !PRIMARY_CLOCK_OUT[7];
  endproperty
  a_gate_stop: assert property (p_gate_stop) else $error("Stopped network still toggles."); // R8 R11

endmodule : pcmg_clock_ctrl

// ### rtl/pcmg_gate.sv
// One primary network clock gate with a registered output.
// Assumes the clock level and enable are already in the system clock domain.
module pcmg_gate
  import pcmg_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // Network side
  pcmg_net_if.gate  net
);

  logic gated_q;

  // ----------------------------------------------------------------
  // Gate
  // ----------------------------------------------------------------
  // A stopped network parks low so downstream logic sees no half pulse.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gated_q <= GATE_OFF_LEVEL;
    end else if (net.gate_enable) begin
      gated_q <= net.gate_clock_in; // R8
    end else begin
      gated_q <= GATE_OFF_LEVEL; // R11
    end
  end

  assign net.gated_clock_out = gated_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_held_off;
    !net.gate_enable [*3];
  endsequence

  property p_gate_pass;
    @(posedge clk_sys) disable iff (reset)
      net.gate_enable |=> net.gated_clock_out == $past(net.gate_clock_in);
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("Enabled gate did not pass its clock."); // R8

  property p_gate_low;
    @(posedge clk_sys) disable iff (reset)
      s_held_off |-> (net.gated_clock_out == GATE_OFF_LEVEL) [*2];
  endproperty
  a_gate_low: assert property (p_gate_low) else $error("Disabled gate output not held low."); // R11

endmodule : pcmg_gate

// ### rtl/pcmg_net_if.sv
// Carrier between the top block and one primary network gate.
// Assumes both ends sit on the system clock.
interface pcmg_net_if;

  logic gate_clock_in;
  logic gate_enable;
  logic gated_clock_out;

  modport gate (input gate_clock_in, input gate_enable, output gated_clock_out);
  modport net  (output gate_clock_in, output gate_enable, input gated_clock_out);

endinterface : pcmg_net_if

// ### rtl/pcmg_pkg.sv
// Constants shared by the primary clock mux and gate block.
// Assumes one system clock; clocks handled here are sampled levels in that domain.
package pcmg_pkg;

  // ----------------------------------------------------------------
  // Network counts
  // ----------------------------------------------------------------
  localparam int NUM_PRIMARY_NETS = 8;
  localparam int NUM_MUX_NETS     = 2;
  localparam int NUM_EDGE_CLOCKS  = 4;

  // ----------------------------------------------------------------
  // Source counts, one group per kind of primary clock source
  // ----------------------------------------------------------------
  localparam int NUM_PIN_SOURCES  = 4;
  localparam int NUM_PLL_SOURCES  = 2;
  localparam int NUM_DIV_SOURCES  = 4;
  localparam int NUM_NODE_SOURCES = 4;

  // ----------------------------------------------------------------
  // Levels and codes
  // ----------------------------------------------------------------
  localparam logic SEL_INPUT_ZERO = 1'b0;
  localparam logic GATE_OFF_LEVEL = 1'b0;
  localparam logic CLOCK_RESET_LEVEL = 1'b0;

endpackage : pcmg_pkg

// ### tb/pcmg_core_model.sv
// Core logic model that drives the mux selects, gate enables and edge selects.
// Assumes requests from the bench arrive on the system clock.
module pcmg_core_model
  import pcmg_pkg::*;
(
  // Clock
  input  wire logic                        clk_sys,
  // Requests from the bench
  input  wire logic [NUM_MUX_NETS-1:0]     want_sel,
  input  wire logic [NUM_PRIMARY_NETS-1:0] net_idle,
  input  wire logic [NUM_EDGE_CLOCKS-1:0]  want_edge,
  // Core logic outputs
  output logic      [NUM_MUX_NETS-1:0]     mux_sel_q     = '0,
  output logic      [NUM_PRIMARY_NETS-1:0] gate_enable_q = '0,
  output logic      [NUM_EDGE_CLOCKS-1:0]  edge_sel_q    = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Real core flops change just after an edge, so the block sees one cycle of delay.
  always_ff @(posedge clk_sys) begin
    mux_sel_q <= want_sel;
  end
  // An idle domain loses its enable so that its logic stops toggling.
  always_ff @(posedge clk_sys) begin
    gate_enable_q <= ~net_idle;
  end
  always_ff @(posedge clk_sys) begin
    edge_sel_q <= want_edge;
  end
endmodule : pcmg_core_model

// ### tb/pcmg_tb.sv
// Self-checking bench for the primary clock mux and gate block.
// Assumes static source levels settle through the two-flop samplers in five edges.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pcmg_pkg::*;
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [13:0]           src_q = '0;
  logic [3:0]            ez_q = '0, eo_q = '0, want_edge_q = '0, edge_sel, edge_out;
  logic [7:0][3:0]       net_src_q = '0;
  logic [1:0][3:0]       one_src_q = '0;
  logic [1:0]            want_sel_q = '0, mux_sel, muxed;
  logic [7:0]            idle_q = '0, gate_en, prim;
  int                    fails = 0, checked = 0, cycles = 0;

  initial begin
    forever #20 clk = ~clk;
  end

  pcmg_core_model core (.clk_sys(clk), .want_sel(want_sel_q), .net_idle(idle_q), .want_edge(want_edge_q),
    .mux_sel_q(mux_sel), .gate_enable_q(gate_en), .edge_sel_q(edge_sel));

  pcmg_clock_ctrl dut (.CLK_SYS(clk), .RESET(rst), .PIN_CLK(src_q[3:0]), .PLL_CLK(src_q[5:4]),
    .DIVIDED_CLOCK_OUTPUT(src_q[9:6]), .NODE_CLK(src_q[13:10]), .NET_SRC(net_src_q), .MUX_ONE_SRC(one_src_q),
    .MUX_SEL(mux_sel), .GATE_ENABLE(gate_en), .EDGE_CLOCK_IN_ZERO(ez_q), .EDGE_CLOCK_IN_ONE(eo_q),
    .EDGE_BRIDGE_SOURCE_SELECT(edge_sel), .MUXED_CLOCK_OUT(muxed), .PRIMARY_CLOCK_OUT(prim),
    .EDGE_CLOCK_OUT(edge_out));

  task automatic edges(input int n);
    repeat (n) @(posedge clk);
  endtask : edges

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("Checks made %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    edges(6);
    #1;
    check("mux and edge outputs in reset", {2'b00, muxed, edge_out}, 8'h00);
    check("network outputs in reset", prim, 8'h00);
  endtask : t_reset

  // Every source index, with every other source low, must reach net 2; spare indices give 0.
  task automatic t_route;
    for (int i = 0; i < 16; i++) begin
      edges(1);
      src_q <= (i < 14) ? (14'h0001 << i) : 14'h3FFF;
      net_src_q[2] <= i[3:0];
      edges(5);
      #1;
      check("net 2 routed source", {7'h00, prim[2]}, {7'h00, i < 14});
    end
  endtask : t_route

  // One network enabled at a time; the rest must sit low even with a high source.
  task automatic t_gate;
    for (int k = 0; k <= 8; k++) begin
      edges(1);
      src_q <= 14'h3FFF;
      net_src_q <= '0;
      idle_q <= (k < 8) ? ~(8'h01 << k) : 8'hFF;
      edges(6);
      #1;
      check("gated networks", prim, (k < 8) ? (8'h01 << k) : 8'h00);
    end
  endtask : t_gate

  // Select flips with input zero high and input one low; output follows one edge after the select.
  task automatic t_mux;
    for (int m = 0; m < 2; m++) begin
      edges(1);
      src_q <= 14'h0001;
      net_src_q <= '0;
      one_src_q[m] <= 4'h1;
      idle_q <= 8'h00;
      want_sel_q <= 2'b00;
      edges(6);
      #1;
      check("mux default input zero", {7'h00, muxed[m]}, 8'h01);
      edges(1);
      want_sel_q <= 2'b11;
      edges(1);
      #1;
      check("mux before select seen", {7'h00, muxed[m]}, 8'h01);
      edges(1);
      #1;
      check("mux after select", {7'h00, muxed[m]}, 8'h00);
      edges(1);
      #1;
      check("mux drives network", {6'h00, prim[m], prim[2]}, 8'h01);
    end
  endtask : t_mux

  task automatic t_edge;
    logic [3:0] pats [3];
    pats = '{4'h0, 4'hF, 4'h6};
    for (int s = 0; s < 3; s++) begin
      edges(1);
      ez_q <= 4'hA;
      eo_q <= 4'h5;
      want_edge_q <= pats[s];
      edges(6);
      #1;
      check("edge bridge select", {4'h0, edge_out}, {4'h0, (4'h5 & pats[s]) | (4'hA & ~pats[s])});
    end
  endtask : t_edge

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    t_reset();
    edges(6);
    rst <= 1'b0;
    edges(3);
    t_route();
    t_gate();
    t_mux();
    t_edge();
    close_out();
  end
endmodule : testbench
